// File: auto_low_limit_lowering_pkg.sv
package auto_low_limit_lowering_pkg;

  // Register offsets
  localparam logic [7:0] OFS_STEP = 8'hB4;
  localparam logic [7:0] OFS_AMB = 8'hB5;
  localparam logic [7:0] OFS_DLY = 8'hB6;
  localparam logic [7:0] OFS_EN = 8'hB7;
  localparam logic [7:0] OFS_STS = 8'hB8;
  localparam logic [7:0] OFS_RSVA = 8'hBA;
  localparam logic [7:0] OFS_RSVB = 8'hBB;
  localparam logic [7:0] OFS_MASK = 8'hBC;

  // Reset values
  localparam logic [7:0] RST_STEP = 8'h00;
  localparam logic [7:0] RST_AMB = 8'h00;
  localparam logic [7:0] RST_DLY = 8'h00;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [2:0] RST_STS = 3'h0;
  localparam logic [7:0] RST_RSVA = 8'h03;
  localparam logic [7:0] RST_RSVB = 8'h00;
  localparam logic [2:0] RST_MASK = 3'h7;

  // Field positions
  localparam int Z1_STEP_LSB = 6;
  localparam int Z3_STEP_LSB = 4;
  localparam int AMB_STEP_LSB = 4;
  localparam int AMB_DLY_LSB = 0;
  localparam int Z1_DLY_LSB = 6;
  localparam int Z3_DLY_LSB = 4;
  localparam int TOP_INT_EN_BIT = 0;
  localparam int ADJ_EN_LSB = 1;

  // Zone indices, equal to the status bit positions
  localparam int NZONE = 3;
  localparam int ZONE_AMB = 0;
  localparam int ZONE_R1 = 1;
  localparam int ZONE_R2 = 2;

  // Step and delay units
  localparam logic [3:0] STEP_UNIT_DEG = 4'h2;
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned CLK_HZ = 250000000;
  localparam longint unsigned CYC_PER_MIN = MINUTE_S * CLK_HZ;

  typedef struct packed {
    logic [7:0] reading;
    logic [7:0] top;
  } auto_low_limit_lowering_zone_t;

  typedef struct packed {
    logic lower;
    logic [3:0] amount;
  } auto_low_limit_lowering_adj_t;

  typedef enum logic [0:0] {
    ZS_ARMED = 1'b0,
    ZS_HOLD = 1'b1
  } auto_low_limit_lowering_zst_t;

endpackage

// File: auto_low_limit_lowering_core.sv
// What this block does
// - While the lock input is high, writes to the step, delay and enable registers are ignored.
// - An enabled zone whose reading reaches its top temperature gets its low limit lowered.
// - A 2-bit delay code sets 1, 2, 3 or 4 minutes before the next lowering, 1 at reset.
// - The remote step register holds zone 1 in bits 7:6 and zone 3 in bits 5:4.
// - The ambient register holds its step in bits 5:4 and its delay in bits 1:0.
// - The remote delay register holds zone 1 in bits 7:6 and zone 3 in bits 5:4.
// - Enable bits 3, 2 and 1 switch lowering on for zone 3, zone 1 and ambient, off at reset.
// - Enable bit 0 lets any set over-top status bit whose mask register bit is set request an interrupt.
// - The interrupt pin goes active only while the global interrupt enable is also high.
// - Status bits 2, 1 and 0 set when zone 3, zone 1 or ambient reads above its top.
// - A status bit clears on a written one only once its zone is no longer over the top.
// - The status register goes to zero when main power good rises.
// - The top temperature is the comparison point; a disabled zone ignores it for lowering but still sets its status bit.
`timescale 1ns/10ps
`default_nettype none

module auto_low_limit_lowering_core #(
  parameter longint unsigned CYC_PER_MIN = auto_low_limit_lowering_pkg::CYC_PER_MIN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Controls from the rest of the monitor
  input wire logic lock_on,
  input wire logic global_int_en,
  input wire logic main_power_good,
  // Zone readings and top limits
  input wire auto_low_limit_lowering_pkg::auto_low_limit_lowering_zone_t zone_in [auto_low_limit_lowering_pkg::NZONE],
  // Low-limit lowering requests
  output auto_low_limit_lowering_pkg::auto_low_limit_lowering_adj_t adj_out [auto_low_limit_lowering_pkg::NZONE],
  output logic auto_low_limit_lowering,
  // Interrupt
  output logic monitor_irq_pin_n
);

  localparam longint unsigned MAX_CYC = 4 * CYC_PER_MIN;
  localparam int CW = $clog2(MAX_CYC + 1);

  // Writable bits come from the field positions, so reserved bits always read zero
  localparam logic [7:0] STEP_WMASK = (8'h03 << auto_low_limit_lowering_pkg::Z1_STEP_LSB) |
    (8'h03 << auto_low_limit_lowering_pkg::Z3_STEP_LSB);
  localparam logic [7:0] AMB_WMASK = (8'h03 << auto_low_limit_lowering_pkg::AMB_STEP_LSB) |
    (8'h03 << auto_low_limit_lowering_pkg::AMB_DLY_LSB);
  localparam logic [7:0] DLY_WMASK = (8'h03 << auto_low_limit_lowering_pkg::Z1_DLY_LSB) |
    (8'h03 << auto_low_limit_lowering_pkg::Z3_DLY_LSB);
  localparam logic [7:0] EN_WMASK = (8'h07 << auto_low_limit_lowering_pkg::ADJ_EN_LSB) |
    (8'h01 << auto_low_limit_lowering_pkg::TOP_INT_EN_BIT);

  // The four minute count must not wrap the 64-bit arithmetic
  if (CYC_PER_MIN < 1 || CYC_PER_MIN > 64'h0FFF_FFFF_FFFF_FFFF) begin : g_chk
    $error("CYC_PER_MIN out of range");
  end

  // Step code to degrees
  function automatic logic [3:0] step_deg(input logic [1:0] code);
    step_deg = 4'(({2'h0, code} + 4'h1) * auto_low_limit_lowering_pkg::STEP_UNIT_DEG);
  endfunction

  // Delay code to hold count, one less than the cycles held
  function automatic logic [CW-1:0] dly_cycles(input logic [1:0] code);
    dly_cycles = CW'((64'(code) + 64'h1) * CYC_PER_MIN - 64'h1);
  endfunction

  // Register state
  logic [7:0] step_q, step_d;
  logic [7:0] amb_q, amb_d;
  logic [7:0] dly_q, dly_d;
  logic [7:0] en_q, en_d;
  logic [2:0] mask_q, mask_d;
  logic [7:0] rsva_q, rsva_d;
  logic [7:0] rdata_q, rdata_d;

  // Status and power-good state
  logic [2:0] sts_q, sts_d;
  logic pg_s1_q, pg_s2_q, pg_prev_q;
  logic pg_rise;
  logic irq_n_q, irq_n_d;

  // Zone state
  auto_low_limit_lowering_pkg::auto_low_limit_lowering_zst_t zst_q [auto_low_limit_lowering_pkg::NZONE];
  auto_low_limit_lowering_pkg::auto_low_limit_lowering_zst_t zst_d [auto_low_limit_lowering_pkg::NZONE];
  logic [CW-1:0] cnt_q [auto_low_limit_lowering_pkg::NZONE];
  logic [CW-1:0] cnt_d [auto_low_limit_lowering_pkg::NZONE];
  auto_low_limit_lowering_pkg::auto_low_limit_lowering_adj_t adj_q [auto_low_limit_lowering_pkg::NZONE];
  auto_low_limit_lowering_pkg::auto_low_limit_lowering_adj_t adj_d [auto_low_limit_lowering_pkg::NZONE];
  logic busy_q, busy_d;

  // Per-zone views of the fields
  logic [1:0] step_code [auto_low_limit_lowering_pkg::NZONE];
  logic [1:0] dly_code [auto_low_limit_lowering_pkg::NZONE];
  logic [2:0] adj_en;
  logic [2:0] over;
  logic [2:0] reach;

  assign step_code[auto_low_limit_lowering_pkg::ZONE_R1] = step_q[auto_low_limit_lowering_pkg::Z1_STEP_LSB +: 2];
  assign step_code[auto_low_limit_lowering_pkg::ZONE_R2] = step_q[auto_low_limit_lowering_pkg::Z3_STEP_LSB +: 2];
  assign step_code[auto_low_limit_lowering_pkg::ZONE_AMB] = amb_q[auto_low_limit_lowering_pkg::AMB_STEP_LSB +: 2];
  assign dly_code[auto_low_limit_lowering_pkg::ZONE_R1] = dly_q[auto_low_limit_lowering_pkg::Z1_DLY_LSB +: 2];
  assign dly_code[auto_low_limit_lowering_pkg::ZONE_R2] = dly_q[auto_low_limit_lowering_pkg::Z3_DLY_LSB +: 2];
  assign dly_code[auto_low_limit_lowering_pkg::ZONE_AMB] = amb_q[auto_low_limit_lowering_pkg::AMB_DLY_LSB +: 2];
  // Enable bits 1..3 line up with zone indices 0..2
  assign adj_en = en_q[auto_low_limit_lowering_pkg::ADJ_EN_LSB +: 3];

  // Readings are two's complement degrees
  always_comb begin
    for (int i = 0; i < auto_low_limit_lowering_pkg::NZONE; i++) begin
      over[i] = $signed(zone_in[i].reading) > $signed(zone_in[i].top);
      reach[i] = $signed(zone_in[i].reading) >= $signed(zone_in[i].top);
    end
  end

  // Register file
  always_comb begin
    step_d = step_q;
    amb_d = amb_q;
    dly_d = dly_q;
    en_d = en_q;
    mask_d = mask_q;
    rsva_d = rsva_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        auto_low_limit_lowering_pkg::OFS_STEP: begin
          if (!lock_on) begin
            step_d = reg_wdata & STEP_WMASK;
          end
        end
        auto_low_limit_lowering_pkg::OFS_AMB: begin
          if (!lock_on) begin
            amb_d = reg_wdata & AMB_WMASK;
          end
        end
        auto_low_limit_lowering_pkg::OFS_DLY: begin
          if (!lock_on) begin
            dly_d = reg_wdata & DLY_WMASK;
          end
        end
        auto_low_limit_lowering_pkg::OFS_EN: begin
          if (!lock_on) begin
            en_d = reg_wdata & EN_WMASK;
          end
        end
        auto_low_limit_lowering_pkg::OFS_MASK: begin
          mask_d = reg_wdata[2:0];
        end
        auto_low_limit_lowering_pkg::OFS_RSVA: begin
          // Stored as written; it steers nothing here
          rsva_d = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        auto_low_limit_lowering_pkg::OFS_STEP: rdata_d = step_q;
        auto_low_limit_lowering_pkg::OFS_AMB: rdata_d = amb_q;
        auto_low_limit_lowering_pkg::OFS_DLY: rdata_d = dly_q;
        auto_low_limit_lowering_pkg::OFS_EN: rdata_d = en_q;
        auto_low_limit_lowering_pkg::OFS_STS: rdata_d = {5'h00, sts_q};
        auto_low_limit_lowering_pkg::OFS_RSVA: rdata_d = rsva_q;
        auto_low_limit_lowering_pkg::OFS_RSVB: rdata_d = auto_low_limit_lowering_pkg::RST_RSVB;
        auto_low_limit_lowering_pkg::OFS_MASK: rdata_d = {5'h00, mask_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_q <= auto_low_limit_lowering_pkg::RST_STEP;
      amb_q <= auto_low_limit_lowering_pkg::RST_AMB;
      dly_q <= auto_low_limit_lowering_pkg::RST_DLY;
      en_q <= auto_low_limit_lowering_pkg::RST_EN;
      mask_q <= auto_low_limit_lowering_pkg::RST_MASK;
      rsva_q <= auto_low_limit_lowering_pkg::RST_RSVA;
      rdata_q <= 8'h00;
    end else begin
      step_q <= step_d;
      amb_q <= amb_d;
      dly_q <= dly_d;
      en_q <= en_d;
      mask_q <= mask_d;
      rsva_q <= rsva_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Power good arrives from another domain
  assign pg_rise = pg_s2_q && !pg_prev_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Power good idles high; a chain reset low would fake a rise after reset
      pg_s1_q <= 1'b1;
      pg_s2_q <= 1'b1;
      pg_prev_q <= 1'b1;
    end else begin
      pg_s1_q <= main_power_good;
      pg_s2_q <= pg_s1_q;
      pg_prev_q <= pg_s2_q;
    end
  end

  // Over-top status; a live condition wins over a written clear, a power-good rise wins over both
  always_comb begin
    sts_d = sts_q;
    for (int i = 0; i < auto_low_limit_lowering_pkg::NZONE; i++) begin
      if (over[i]) begin
        sts_d[i] = 1'b1;
      end else if (reg_wr && reg_addr == auto_low_limit_lowering_pkg::OFS_STS && reg_wdata[i]) begin
        sts_d[i] = 1'b0;
      end
    end
    if (pg_rise) begin
      sts_d = auto_low_limit_lowering_pkg::RST_STS;
    end
  end

  // Interrupt, registered so the pin is glitch free
  always_comb begin
    irq_n_d = 1'b1;
    if (en_q[auto_low_limit_lowering_pkg::TOP_INT_EN_BIT] && global_int_en) begin
      irq_n_d = !(|(sts_q & mask_q));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sts_q <= auto_low_limit_lowering_pkg::RST_STS;
      irq_n_q <= 1'b1;
    end else begin
      sts_q <= sts_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign monitor_irq_pin_n = irq_n_q;

  // Zone lowering sequencers
  always_comb begin
    busy_d = 1'b0;
    for (int i = 0; i < auto_low_limit_lowering_pkg::NZONE; i++) begin
      zst_d[i] = zst_q[i];
      cnt_d[i] = cnt_q[i];
      adj_d[i].lower = 1'b0;
      adj_d[i].amount = adj_q[i].amount;
      if (!adj_en[i]) begin
        // Top limit plays no part in lowering for a disabled zone
        zst_d[i] = auto_low_limit_lowering_pkg::ZS_ARMED;
        cnt_d[i] = '0;
      end else begin
        unique case (zst_q[i])
          auto_low_limit_lowering_pkg::ZS_ARMED: begin
            if (reach[i]) begin
              adj_d[i].lower = 1'b1;
              adj_d[i].amount = step_deg(step_code[i]);
              zst_d[i] = auto_low_limit_lowering_pkg::ZS_HOLD;
              cnt_d[i] = dly_cycles(dly_code[i]);
            end
          end
          auto_low_limit_lowering_pkg::ZS_HOLD: begin
            // Delay code changes take effect at the next lowering
            if (cnt_q[i] == '0) begin
              zst_d[i] = auto_low_limit_lowering_pkg::ZS_ARMED;
            end else begin
              cnt_d[i] = cnt_q[i] - CW'(1);
            end
          end
        endcase
      end
      busy_d = busy_d | (zst_d[i] == auto_low_limit_lowering_pkg::ZS_HOLD);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < auto_low_limit_lowering_pkg::NZONE; i++) begin
        zst_q[i] <= auto_low_limit_lowering_pkg::ZS_ARMED;
        cnt_q[i] <= '0;
        adj_q[i] <= '0;
      end
      busy_q <= 1'b0;
    end else begin
      for (int i = 0; i < auto_low_limit_lowering_pkg::NZONE; i++) begin
        zst_q[i] <= zst_d[i];
        cnt_q[i] <= cnt_d[i];
        adj_q[i] <= adj_d[i];
      end
      busy_q <= busy_d;
    end
  end

  assign adj_out = adj_q;
  assign auto_low_limit_lowering = busy_q;

endmodule

`default_nettype wire

// File: auto_low_limit_lowering_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module auto_low_limit_lowering_core_assertions #(
  parameter longint unsigned CYC_PER_MIN = auto_low_limit_lowering_pkg::CYC_PER_MIN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Controls
  input wire logic lock_on,
  input wire logic global_int_en,
  input wire logic main_power_good,
  // Zones
  input wire auto_low_limit_lowering_pkg::auto_low_limit_lowering_zone_t zone_in [auto_low_limit_lowering_pkg::NZONE],
  input wire auto_low_limit_lowering_pkg::auto_low_limit_lowering_adj_t adj_out [auto_low_limit_lowering_pkg::NZONE],
  input wire logic auto_low_limit_lowering,
  input wire logic monitor_irq_pin_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_remote_rsvd_zero:
    assert property ($past(reg_rd) && $past(reg_addr) inside {8'hB4, 8'hB6} |-> reg_rdata[3:0] == 4'h0)
    else $error("remote register reserved bits not zero");
  a_enable_rsvd_zero:
    assert property ($past(reg_rd) && $past(reg_addr) == 8'hB7 |-> reg_rdata[7:4] == 4'h0)
    else $error("enable register reserved bits not zero");
  a_lower_cause:
    assert property (adj_out[1].lower |->
      $signed($past(zone_in[1].reading)) >= $signed($past(zone_in[1].top)))
    else $error("lowering without reaching the top");
  a_lower_amount:
    assert property (adj_out[0].lower |-> adj_out[0].amount inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("lowering amount out of range");
  a_lower_spacing:
    assert property (adj_out[2].lower |=> !adj_out[2].lower [*8])
    else $error("lowering repeated inside the hold");
  a_busy_with_lower:
    assert property (adj_out[0].lower |-> auto_low_limit_lowering)
    else $error("hold flag low at a lowering");
  a_irq_global_gate:
    assert property (!$past(global_int_en) |-> monitor_irq_pin_n)
    else $error("interrupt without global enable");
  a_irq_top_enable:
    assert property (reg_wr && reg_addr == 8'hB7 && !reg_wdata[0] && !lock_on |=> ##1 monitor_irq_pin_n)
    else $error("interrupt with top enable cleared");
  c_lower: cover property (adj_out[1].lower);
  c_irq: cover property (!monitor_irq_pin_n);
  c_lock_write: cover property (reg_wr && lock_on);
endmodule
bind auto_low_limit_lowering_core auto_low_limit_lowering_core_assertions #(.CYC_PER_MIN(CYC_PER_MIN)) u_chk (.clk(clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_on(lock_on), .global_int_en(global_int_en),
  .main_power_good(main_power_good), .zone_in(zone_in), .adj_out(adj_out),
  .auto_low_limit_lowering(auto_low_limit_lowering), .monitor_irq_pin_n(monitor_irq_pin_n));
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // Short minute keeps the hold delays cheap to simulate
  localparam longint unsigned CPM = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic lock_on = 1'b0;
  logic global_int_en = 1'b0;
  logic main_power_good = 1'b0;
  auto_low_limit_lowering_pkg::auto_low_limit_lowering_zone_t zone_in [auto_low_limit_lowering_pkg::NZONE];
  auto_low_limit_lowering_pkg::auto_low_limit_lowering_adj_t adj_out [auto_low_limit_lowering_pkg::NZONE];
  logic auto_low_limit_lowering;
  logic monitor_irq_pin_n;
  int miscompares = 0;
  int checks = 0;
  int gap;
  logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h07};
  logic [7:0] rw_val [4] = '{8'hF0, 8'h33, 8'hF0, 8'h0F};
  auto_low_limit_lowering_core #(.CYC_PER_MIN(CPM)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lock_on(lock_on), .global_int_en(global_int_en), .main_power_good(main_power_good),
    .zone_in(zone_in), .adj_out(adj_out), .auto_low_limit_lowering(auto_low_limit_lowering),
    .monitor_irq_pin_n(monitor_irq_pin_n));
  always #2 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, "reg_rdata");
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, monitor_irq_pin_n}, {7'h00, e}, "monitor_irq_pin_n");
  endtask
  task automatic wait_lower(input int z, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (adj_out[z].lower !== 1'b1 && n < 200);
    chk(8'(n < 200), 8'h01, "lower pulse");
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 3; i++)
      zone_in[i] = '{8'h10, 8'h2D};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd(8'hB4 + 8'(i), rst_val[i]);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(8'hB4 + 8'(i), 8'hFF);
      rd(8'hB4 + 8'(i), rw_val[i]);
      lock_on <= 1'b1;
      wr(8'hB4 + 8'(i), 8'h00);
      rd(8'hB4 + 8'(i), rw_val[i]);
      lock_on <= 1'b0;
      wr(8'hB4 + 8'(i), 8'h00);
    end
    wr(8'hBA, 8'h03);
    rd(8'hBA, 8'h03);
    wr(8'hBB, 8'hFF);
    rd(8'hBB, 8'h00);
    $display("register fields done");
    for (int z = 0; z < 3; z++) begin
      for (int c = 0; c < 4; c++) begin
        logic [7:0] cc;
        cc = 8'(c);
        if (z == 0)
          wr(8'hB5, (cc << 4) | cc);
        else begin
          wr(8'hB4, cc << (z == 1 ? 6 : 4));
          wr(8'hB6, cc << (z == 1 ? 6 : 4));
        end
        wr(8'hB7, 8'h02 << z);
        zone_in[z].reading <= 8'h2D;
        wait_lower(z, gap);
        chk({4'h0, adj_out[z].amount}, 8'(2 * (c + 1)), "amount");
        chk({7'h00, auto_low_limit_lowering}, 8'h01, "auto_low_limit_lowering");
        wait_lower(z, gap);
        chk(8'(gap > (c + 1) * CPM && gap <= (c + 1) * CPM + 2), 8'h01, "delay");
        zone_in[z].reading <= 8'h10;
        wr(8'hB7, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, auto_low_limit_lowering}, 8'h00, "auto_low_limit_lowering");
      end
    end
    $display("adjustment done");
    wr(8'hB7, 8'h01);
    global_int_en <= 1'b1;
    zone_in[1].reading <= 8'h2E;
    rd(8'hB8, 8'h02);
    chk({7'h00, auto_low_limit_lowering}, 8'h00, "auto_low_limit_lowering");
    irq_is(1'b0);
    global_int_en <= 1'b0;
    irq_is(1'b1);
    global_int_en <= 1'b1;
    wr(8'hB7, 8'h00);
    irq_is(1'b1);
    wr(8'hBC, 8'h00);
    wr(8'hB7, 8'h01);
    irq_is(1'b1);
    wr(8'hBC, 8'h07);
    zone_in[0].reading <= 8'h2E;
    zone_in[2].reading <= 8'h2E;
    rd(8'hB8, 8'h07);
    wr(8'hB8, 8'h07);
    rd(8'hB8, 8'h07);
    for (int i = 0; i < 3; i++)
      zone_in[i].reading <= 8'h2D;
    wr(8'hB8, 8'h00);
    rd(8'hB8, 8'h07);
    wr(8'hB8, 8'h02);
    rd(8'hB8, 8'h05);
    irq_is(1'b0);
    main_power_good <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'hB8, 8'h00);
    irq_is(1'b1);
    $display("status and interrupt done");
    stop_test();
  end
endmodule
`default_nettype wire
